//--- inc/mmsh_cfg.svh
// Constants of the subaddress message handler: offsets, field bits, timing.
// Assumes inclusion from the handler package and modules only.
`ifndef MMSH_CFG_SVH
`define MMSH_CFG_SVH
// Subaddress control block word offsets, bytes
`define MMSH_OFF_PTR_OPT  20'h0_0000
`define MMSH_OFF_FLAGS    20'h0_0004
// Data buffer layout, byte offsets
`define MMSH_BUF_NDP      16'h0000
`define MMSH_BUF_CW       16'h0002
`define MMSH_BUF_GAP      16'h000E
`define MMSH_BUF_TT_HI    16'h0010
`define MMSH_BUF_TT_LO    16'h0012
`define MMSH_BUF_ISW      16'h0014
`define MMSH_BUF_TSW      16'h0016
`define MMSH_BUF_DATA     16'h0018
// Monitor option bits
`define MMSH_OPT_NOREC    15
`define MMSH_OPT_START    14
`define MMSH_OPT_STOP     13
`define MMSH_OPT_TTCLR    11
`define MMSH_OPT_TRIG     10
// Subaddress flag bits
`define MMSH_FLG_RING     6
`define MMSH_FLG_VONLY    5
`define MMSH_FLG_MCPTR    4
`define MMSH_FLG_VINT     3
`define MMSH_FLG_EOMINT   2
`define MMSH_FLG_IGNORE   1
`define MMSH_FLG_ILLCW    0
// Command word fields
`define MMSH_TA_BCAST     5'h1F
`define MMSH_SA_MC0       5'h00
`define MMSH_SA_MC31      5'h1F
// Recording state after reset or re-initialisation
`define MMSH_REC_RESET    1'b1
// Trigger pulse: least width in ns, clock period in ns, cycles rounded up
`define MMSH_TRIG_NS      50
`define MMSH_CLK_NS       40
`define MMSH_TRIG_CYC     ((`MMSH_TRIG_NS + `MMSH_CLK_NS - 1) / `MMSH_CLK_NS)
`endif

//--- inc/mmsh_pkg.sv
// Types of the subaddress message handler.
// Assumes the cfg header sits in the include path.
`include "mmsh_cfg.svh"
package mmsh_pkg;
    // Message sequencer states
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_OPT  = 3'b001,
        ST_FLG  = 3'b010,
        ST_DEC  = 3'b011,
        ST_END  = 3'b100
    } mmsh_state_e;

    // Whole state of the handler
    typedef struct packed {
        mmsh_state_e st;
        logic        mem_rd;
        logic [19:0] mem_addr;
        logic [15:0] cw;
        logic [15:0] opt;
        logic [15:0] flg;
        logic        rec;
        logic        dec_stb;
        logic        ignore;
        logic        record;
        logic        to_ring;
        logic        fetch_ndp;
        logic        mc_ill;
        logic        mc_int;
        logic [15:0] buf_addr;
        logic [15:0] data_addr;
        logic [15:0] link;
        logic [31:0] tt;
        logic        sw_err;
        logic        sw_bcast;
        logic        commit;
        logic        irq;
        logic        trig;
        logic        tt_clr;
    } mmsh_top_s;

    // Trigger stretcher state
    typedef struct packed {
        logic [1:0] cnt;
        logic       out;
    } mmsh_pulse_s;

    // Time tag counter state
    typedef struct packed {
        logic [31:0] cnt;
    } mmsh_ttc_s;
endpackage : mmsh_pkg

//--- sim/mmsh_mem_model.sv
// Memory model holding one subaddress control block for the handler.
// Assumes the bench sets both block words before each command word.
`timescale 1ns/100ps
module mmsh_mem_model
    import mmsh_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic        mem_rd,
    input  wire logic [19:0] mem_addr,
    input  wire logic [15:0] opt_word,
    input  wire logic [15:0] flg_word,
    input  wire logic [1:0]  wait_cyc,
    output logic             mem_ack,
    output logic [15:0]      mem_rdata
);
    ////////////////////////////////////////////////////////////////////////
    logic [1:0]  wait_q;  // Cycles already waited on this read
    logic [15:0] last_q;  // Last word handed over
    // Answer once the chosen wait has passed
    assign mem_ack = mem_rd && (wait_q >= wait_cyc);
    // Offset 0 holds pointer or options, offset 4 the flags; else garbage
    assign mem_rdata = !mem_ack ? ~last_q : (mem_addr[2] ? flg_word : opt_word);
    // Wait counter and last word
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wait_q <= 2'h0;
            last_q <= 16'h0000;
        end else begin
            wait_q <= (mem_rd && !mem_ack) ? wait_q + 2'h1 : 2'h0;
            if (mem_ack) begin
                last_q <= mem_rdata;
            end
        end
    end
endmodule : mmsh_mem_model

//--- sim/tb_mmsh_top.sv
// Self-checking bench of the subaddress message handler.
// Assumes the memory model answers the control block reads.
`timescale 1ns/100ps
module tb_mmsh_top
    import mmsh_pkg::*;
;
    ////////////////////////////////////////////////////////////////////////
    logic        clk, rstn, reinit, sim_mode, bcast_en, bcast_mc_dis, ndp_dma_dis;
    logic [19:0] sa_cb_base, mem_addr;
    logic [15:0] mode_ptr, ring_cur, ring_next, cmd_word, mem_rdata, opt_w, flg_w;
    logic [31:0] mc_enable, mc_int_en, dec_time_tag, g_tt;
    logic        ring_last, cmd_stb, msg_done, msg_valid, mem_ack, mem_rd, dec_stb;
    logic        dec_ignore, dec_record, dec_to_ring, dec_fetch_ndp, sw_msg_err;
    logic        sw_bcast, rec_on, commit_stb, irq_stb, scope_trig, g_dec, g_com, g_irq;
    logic [15:0] dec_buf_addr, dec_data_addr, dec_link;
    logic [1:0]  wait_cyc;       // Memory answer delay
    int          fails, check_count, cyc, g_trig, g_cyc, g_dcyc, t1, c1;
    // Design and its memory
    mmsh_top dut (.clk, .rstn, .reinit, .sim_mode, .bcast_en, .bcast_mc_dis,
        .ndp_dma_dis, .sa_cb_base, .mode_ptr, .mc_enable, .mc_int_en, .ring_cur,
        .ring_next, .ring_last, .cmd_stb, .cmd_word, .msg_done, .msg_valid, .mem_ack,
        .mem_rdata, .mem_rd, .mem_addr, .dec_stb, .dec_ignore, .dec_record,
        .dec_to_ring, .dec_fetch_ndp, .dec_buf_addr, .dec_data_addr, .dec_link,
        .dec_time_tag, .sw_msg_err, .sw_bcast, .rec_on, .commit_stb, .irq_stb,
        .scope_trig);
    mmsh_mem_model mem (.clk, .rstn, .mem_rd, .mem_addr, .opt_word(opt_w),
        .flg_word(flg_w), .wait_cyc, .mem_ack, .mem_rdata);
    // Clock and cycle count
    always #20 clk = ~clk;
    always @(posedge clk) cyc++;
    ////////////////////////////////////////////////////////////////////////
    // Command word: terminal, receive, subaddress, count or mode code
    function automatic logic [15:0] cw(input logic [4:0] ta, sa, wc);
        return {ta, 1'b0, sa, wc};
    endfunction : cw
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic wrap_up();
        $display("checks=%0d fails=%0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : wrap_up
    // One message: command, wait for decision, end with validity v
    task automatic msg(input logic [15:0] c, o, f, input logic v, want);
        int n;
        opt_w = o;
        flg_w = f;
        cmd_word = c;
        cmd_stb = 1'b1;
        g_cyc = cyc;
        @(negedge clk);
        cmd_stb = 1'b0;
        g_dec = 1'b0;
        g_trig = 0;
        n = 0;
        while (!g_dec && n < 12) begin
            @(negedge clk);
            n++;
            if (dec_stb === 1'b1) begin
                g_dec = 1'b1;
                g_tt = dec_time_tag;
                g_dcyc = cyc;
            end
        end
        if (want && !g_dec) begin
            chk(g_dec, 1'b1);
            wrap_up();
        end
        repeat (3) begin
            @(negedge clk);
            if (scope_trig === 1'b1) g_trig++;
        end
        msg_valid = v;
        msg_done = 1'b1;
        @(negedge clk);
        msg_done = 1'b0;
        g_com = commit_stb;
        g_irq = irq_stb;
        @(negedge clk);
    endtask : msg
    ////////////////////////////////////////////////////////////////////////
    task automatic t_sim();
        sim_mode = 1'b1;
        msg(cw(5'h03, 5'h02, 5'h04), 16'h1200, 16'h0000, 1'b1, 1'b1);
        t1 = g_tt;
        c1 = g_cyc;
        chk(dec_buf_addr, 16'h1200);
        chk(dec_data_addr, 16'h1218);
        chk({dec_record, dec_to_ring, dec_fetch_ndp}, 3'b101);
        chk({mem_rd, mem_addr}, {1'b0, 20'h0_1004});
        wait_cyc = 2'h2;
        msg(cw(5'h03, 5'h02, 5'h04), 16'h1200, 16'h0000, 1'b1, 1'b1);
        chk(dec_buf_addr, 16'h1200);
        chk(g_tt - t1, 32'(g_cyc - c1));
        ndp_dma_dis = 1'b1;
        msg(cw(5'h03, 5'h02, 5'h04), 16'h1200, 16'h0000, 1'b1, 1'b1);
        chk(dec_fetch_ndp, 1'b0);
        ndp_dma_dis = 1'b0;
        wait_cyc = 2'h0;
        msg(cw(5'h03, 5'h02, 5'h04), 16'h1200, 16'h0040, 1'b1, 1'b1);
        chk({dec_to_ring, dec_fetch_ndp}, 2'b10);
        $display("t_sim done");
    endtask : t_sim
    task automatic t_flags();
        msg(cw(5'h03, 5'h04, 5'h01), 16'h1200, 16'h0060, 1'b0, 1'b1);
        chk(g_com, 1'b0);
        msg(cw(5'h03, 5'h04, 5'h01), 16'h1200, 16'h0060, 1'b1, 1'b1);
        chk(g_com, 1'b1);
        msg(cw(5'h03, 5'h04, 5'h01), 16'h1200, 16'h0004, 1'b0, 1'b1);
        chk(g_irq, 1'b1);
        // Valid-only interrupt also carries the end-of-message flag
        msg(cw(5'h03, 5'h04, 5'h01), 16'h1200, 16'h000C, 1'b0, 1'b1);
        chk(g_irq, 1'b0);
        msg(cw(5'h03, 5'h04, 5'h01), 16'h1200, 16'h000C, 1'b1, 1'b1);
        chk(g_irq, 1'b1);
        msg(cw(5'h03, 5'h05, 5'h01), 16'h1200, 16'h0007, 1'b1, 1'b0);
        chk({g_dec, g_com, g_irq, sw_msg_err, dec_ignore}, 5'h01);
        msg(cw(5'h03, 5'h05, 5'h01), 16'h1200, 16'h0001, 1'b1, 1'b1);
        chk(sw_msg_err, 1'b1);
        $display("t_flags done");
    endtask : t_flags
    task automatic t_mc();
        mc_enable = 32'h0002_0002;
        mc_int_en = 32'hFFFF_FFFF;
        msg(cw(5'h03, 5'h00, 5'h03), 16'h1300, 16'h0004, 1'b1, 1'b1);
        chk(sw_msg_err, 1'b1);
        chk(g_irq, 1'b0);
        msg(cw(5'h03, 5'h1F, 5'h11), 16'h1300, 16'h0010, 1'b1, 1'b1);
        chk({sw_msg_err, g_irq}, 2'b01);
        chk(dec_buf_addr, 16'h2400);
        $display("t_mc done");
    endtask : t_mc
    task automatic t_bcast();
        bcast_en = 1'b1;
        msg(cw(5'h1F, 5'h02, 5'h01), 16'h1200, 16'h0000, 1'b1, 1'b1);
        chk(sw_bcast, 1'b1);
        bcast_mc_dis = 1'b1;
        msg(cw(5'h1F, 5'h00, 5'h01), 16'h1200, 16'h0000, 1'b1, 1'b1);
        chk(sw_msg_err, 1'b1);
        bcast_mc_dis = 1'b0;
        msg(cw(5'h1F, 5'h00, 5'h01), 16'h1200, 16'h0000, 1'b1, 1'b1);
        chk(sw_msg_err, 1'b0);
        bcast_en = 1'b0;
        msg(cw(5'h1F, 5'h02, 5'h01), 16'h1200, 16'h0000, 1'b1, 1'b1);
        chk(sw_bcast, 1'b0);
        $display("t_bcast done");
    endtask : t_bcast
    task automatic t_mon();
        sim_mode = 1'b0;
        msg(cw(5'h06, 5'h02, 5'h01), 16'h0000, 16'h0000, 1'b1, 1'b1);
        chk({dec_record, dec_link}, {1'b1, 16'h3040});
        ring_last = 1'b1;
        msg(cw(5'h06, 5'h02, 5'h01), 16'h8000, 16'h0000, 1'b1, 1'b1);
        chk({dec_record, dec_link}, {1'b0, 16'h3000});
        msg(cw(5'h06, 5'h02, 5'h01), 16'h2000, 16'h0000, 1'b1, 1'b1);
        chk(rec_on, 1'b0);
        msg(cw(5'h06, 5'h02, 5'h01), 16'h0000, 16'h0000, 1'b1, 1'b1);
        chk(dec_record, 1'b0);
        msg(cw(5'h06, 5'h02, 5'h01), 16'h4000, 16'h0000, 1'b1, 1'b1);
        chk({dec_record, rec_on}, 2'b11);
        msg(cw(5'h06, 5'h02, 5'h01), 16'h2000, 16'h0000, 1'b1, 1'b1);
        reinit = 1'b1;
        @(negedge clk);
        reinit = 1'b0;
        chk(rec_on, 1'b1);
        msg(cw(5'h06, 5'h02, 5'h01), 16'h0C00, 16'h0000, 1'b1, 1'b1);
        chk(g_trig, 2);
        c1 = g_dcyc;
        msg(cw(5'h06, 5'h02, 5'h01), 16'h0000, 16'h0000, 1'b1, 1'b1);
        chk(g_tt, 32'(g_cyc - c1 - 1));
        $display("t_mon done");
    endtask : t_mon
    ////////////////////////////////////////////////////////////////////////
    // Reset for three cycles, then the scenarios
    initial begin
        {clk, rstn, reinit, sim_mode, bcast_en, bcast_mc_dis, ndp_dma_dis} = 7'h00;
        {ring_last, cmd_stb, msg_done, msg_valid} = 4'h0;
        {cmd_word, opt_w, flg_w, mc_enable, mc_int_en} = 112'h0;
        sa_cb_base = 20'h0_1000;
        mode_ptr = 16'h2400;
        ring_cur = 16'h3000;
        ring_next = 16'h3040;
        wait_cyc = 2'h0;
        repeat (3) @(posedge clk);
        @(negedge clk);
        rstn = 1'b1;
        t_sim();
        t_flags();
        t_mc();
        t_bcast();
        t_mon();
        wrap_up();
    end
endmodule : tb_mmsh_top

//--- src/mmsh_pulse.sv
// Scope trigger stretcher: one start cycle becomes a pulse of fixed width.
// Assumes start is a one-cycle strobe on clk.
`timescale 1ns/100ps
`include "mmsh_cfg.svh"
module mmsh_pulse
    import mmsh_pkg::*;
(
    input  wire logic clk,
    input  wire logic rstn,
    input  wire logic start,
    output logic      pulse
);
    mmsh_pulse_s s_q;   // Registered state
    mmsh_pulse_s s_d;   // Next state

    ////////////////////////////////////////////////////////////////////////
    // Load the width on start, count down to zero
    always_comb begin
        s_d = s_q;
        if (start) begin
            s_d.cnt = 2'(`MMSH_TRIG_CYC);
            s_d.out = 1'b1;
        end else if (s_q.cnt > 2'h1) begin
            s_d.cnt = s_q.cnt - 2'h1;
        end else begin
            s_d.cnt = 2'h0;
            s_d.out = 1'b0;
        end
    end

    // State register
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign pulse = s_q.out;

    AST_TRIG_WIDTH: assert property (@(posedge clk) disable iff (!rstn)
        $rose(s_q.out) |-> s_q.out [*2])
        else $error("trigger pulse shorter than two cycles");
endmodule : mmsh_pulse

//--- src/mmsh_top.sv
// Subaddress message handler for terminal simulation and bus monitoring.
// Assumes a protocol engine on clk strobes each valid command word, fetches
// control blocks through the read port below and marks each message end.
`timescale 1ns/100ps
`include "mmsh_cfg.svh"
module mmsh_top
    import mmsh_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic        reinit,
    input  wire logic        sim_mode,
    input  wire logic        bcast_en,
    input  wire logic        bcast_mc_dis,
    input  wire logic        ndp_dma_dis,
    input  wire logic [19:0] sa_cb_base,
    input  wire logic [15:0] mode_ptr,
    input  wire logic [31:0] mc_enable,
    input  wire logic [31:0] mc_int_en,
    input  wire logic [15:0] ring_cur,
    input  wire logic [15:0] ring_next,
    input  wire logic        ring_last,
    input  wire logic        cmd_stb,
    input  wire logic [15:0] cmd_word,
    input  wire logic        msg_done,
    input  wire logic        msg_valid,
    input  wire logic        mem_ack,
    input  wire logic [15:0] mem_rdata,
    output logic             mem_rd,
    output logic [19:0]      mem_addr,
    output logic             dec_stb,
    output logic             dec_ignore,
    output logic             dec_record,
    output logic             dec_to_ring,
    output logic             dec_fetch_ndp,
    output logic [15:0]      dec_buf_addr,
    output logic [15:0]      dec_data_addr,
    output logic [15:0]      dec_link,
    output logic [31:0]      dec_time_tag,
    output logic             sw_msg_err,
    output logic             sw_bcast,
    output logic             rec_on,
    output logic             commit_stb,
    output logic             irq_stb,
    output logic             scope_trig
);
    mmsh_top_s   s_q;       // Registered state
    mmsh_top_s   s_d;       // Next state
    logic [31:0] tt_now;    // Free-running time tag
    logic [4:0]  ta;        // Terminal address of held command
    logic [4:0]  sa;        // Subaddress of held command
    logic [4:0]  mcode;     // Mode code of held command
    logic        is_mc;     // Held command is a mode code
    logic        is_bc;     // Held command is broadcast
    logic        mc_legal;  // Mode code enabled for this terminal
    logic        rec_nx;    // Recording state after this message
    logic        use_mp;    // Mode data pointer selected

    ////////////////////////////////////////////////////////////////////////
    // Time tag counter and scope trigger stretcher
    mmsh_ttc u_ttc (
        .clk   (clk),
        .rstn  (rstn),
        .clr   (s_q.tt_clr),
        .count (tt_now)
    );

    mmsh_pulse u_trig (
        .clk   (clk),
        .rstn  (rstn),
        .start (s_q.trig),
        .pulse (scope_trig)
    );

    ////////////////////////////////////////////////////////////////////////
    // Command word decode
    always_comb begin
        ta    = s_q.cw[15:11];
        sa    = s_q.cw[9:5];
        mcode = s_q.cw[4:0];
        is_mc = (sa == `MMSH_SA_MC0) || (sa == `MMSH_SA_MC31);
        is_bc = bcast_en && (ta == `MMSH_TA_BCAST);
        // Enable bit n of the pair of words, broadcast gated by header
        mc_legal = mc_enable[mcode]
                   && (!is_bc || !bcast_mc_dis);
        // Start wins over stop when both options are set
        if (s_q.opt[`MMSH_OPT_START]) begin
            rec_nx = 1'b1;
        end else if (s_q.opt[`MMSH_OPT_STOP]) begin
            rec_nx = 1'b0;
        end else begin
            rec_nx = s_q.rec;
        end
        use_mp = sim_mode && is_mc && s_q.flg[`MMSH_FLG_MCPTR];
    end

    ////////////////////////////////////////////////////////////////////////
    // Sequencer: fetch options and flags, decide, wait for message end
    always_comb begin
        s_d = s_q;
        s_d.dec_stb = 1'b0;
        s_d.commit  = 1'b0;
        s_d.irq     = 1'b0;
        s_d.trig    = 1'b0;
        s_d.tt_clr  = 1'b0;
        unique case (s_q.st)
            ST_IDLE: begin
                // Accept a command, stamp it, read the first block word
                if (cmd_stb) begin
                    s_d.cw       = cmd_word;
                    s_d.tt       = tt_now;
                    s_d.mem_rd   = 1'b1;
                    s_d.mem_addr = sa_cb_base + `MMSH_OFF_PTR_OPT;
                    s_d.st       = ST_OPT;
                end
            end
            ST_OPT: begin
                // Pointer in simulation, option bits in monitoring
                if (mem_ack) begin
                    s_d.opt      = mem_rdata;
                    s_d.mem_addr = sa_cb_base + `MMSH_OFF_FLAGS;
                    s_d.st       = ST_FLG;
                end
            end
            ST_FLG: begin
                // Flags word closes the fetch
                if (mem_ack) begin
                    s_d.flg    = mem_rdata;
                    s_d.mem_rd = 1'b0;
                    s_d.st     = ST_DEC;
                end
            end
            ST_DEC: begin
                s_d.ignore = s_q.flg[`MMSH_FLG_IGNORE];
                if (s_q.flg[`MMSH_FLG_IGNORE]) begin
                    // Treated as never sent: no decision, no status
                    s_d.st = ST_IDLE;
                end else begin
                    s_d.dec_stb = 1'b1;
                    s_d.mc_ill  = is_mc && !mc_legal;
                    s_d.mc_int  = is_mc && mc_legal && mc_int_en[mcode];
                    s_d.sw_err  = s_q.flg[`MMSH_FLG_ILLCW]
                                  || (is_mc && !mc_legal);
                    s_d.sw_bcast = is_bc;
                    s_d.link = ring_last ? ring_cur : ring_next;
                    if (sim_mode) begin
                        // Single pointer reused unless next pointer moves it
                        s_d.to_ring  = s_q.flg[`MMSH_FLG_RING];
                        s_d.record   = 1'b1;
                        s_d.buf_addr = use_mp ? mode_ptr : s_q.opt;
                        s_d.fetch_ndp = !ndp_dma_dis
                                        && !s_q.flg[`MMSH_FLG_RING];
                    end else begin
                        // Monitor: ring entry, options steer recording
                        s_d.to_ring  = 1'b1;
                        s_d.rec      = rec_nx;
                        s_d.record   = rec_nx
                                       && !s_q.opt[`MMSH_OPT_NOREC];
                        s_d.buf_addr = ring_cur;
                        s_d.fetch_ndp = 1'b0;
                        s_d.trig     = s_q.opt[`MMSH_OPT_TRIG];
                        s_d.tt_clr   = s_q.opt[`MMSH_OPT_TTCLR];
                    end
                    // Data area sits past the overhead words
                    s_d.data_addr = (use_mp ? mode_ptr : s_d.buf_addr)
                                    + `MMSH_BUF_DATA;
                    s_d.st = ST_END;
                end
            end
            ST_END: begin
                // Commit and interrupt decided once validity is known
                if (msg_done) begin
                    s_d.commit = s_q.record && (!s_q.to_ring
                                 || !s_q.flg[`MMSH_FLG_VONLY] || msg_valid);
                    s_d.irq = !s_q.mc_ill && (s_q.mc_int
                              || (s_q.flg[`MMSH_FLG_EOMINT]
                                  && (!s_q.flg[`MMSH_FLG_VINT] || msg_valid)));
                    s_d.st = ST_IDLE;
                end
            end
            default: begin
                s_d.st     = ST_IDLE;
                s_d.mem_rd = 1'b0;
            end
        endcase
        // Re-initialisation resumes recording
        if (reinit) begin
            s_d.rec = `MMSH_REC_RESET;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // State register; recording is on after reset
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s_q     <= '0;
            s_q.rec <= `MMSH_REC_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs straight from the state register
    assign mem_rd        = s_q.mem_rd;
    assign mem_addr      = s_q.mem_addr;
    assign dec_stb       = s_q.dec_stb;
    assign dec_ignore    = s_q.ignore;
    assign dec_record    = s_q.record;
    assign dec_to_ring   = s_q.to_ring;
    assign dec_fetch_ndp = s_q.fetch_ndp;
    assign dec_buf_addr  = s_q.buf_addr;
    assign dec_data_addr = s_q.data_addr;
    assign dec_link      = s_q.link;
    assign dec_time_tag  = s_q.tt;
    assign sw_msg_err    = s_q.sw_err;
    assign sw_bcast      = s_q.sw_bcast;
    assign rec_on        = s_q.rec;
    assign commit_stb    = s_q.commit;
    assign irq_stb       = s_q.irq;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    AST_NOREC: assert property (
        dec_stb && !sim_mode && s_q.opt[`MMSH_OPT_NOREC] |-> !dec_record)
        else $error("no-record message marked for recording");

    AST_STOP: assert property (
        s_q.st == ST_DEC && !sim_mode && !s_q.flg[`MMSH_FLG_IGNORE] && !reinit
        && s_q.opt[`MMSH_OPT_STOP] && !s_q.opt[`MMSH_OPT_START] |=> !rec_on)
        else $error("stop option did not halt recording");

    AST_TRIG: assert property (
        dec_stb && !sim_mode && s_q.opt[`MMSH_OPT_TRIG]
        |=> scope_trig [*2] ##1 !scope_trig)
        else $error("scope trigger not two cycles");

    AST_IGNORE: assert property (
        s_q.st == ST_DEC && s_q.flg[`MMSH_FLG_IGNORE]
        |=> !dec_stb && s_q.st == ST_IDLE ##1 !dec_stb)
        else $error("ignored subaddress produced a decision");

    AST_ILLCW: assert property (
        dec_stb && s_q.flg[`MMSH_FLG_ILLCW] |-> sw_msg_err)
        else $error("illegal flag without status error");

    AST_DATA: assert property (
        dec_stb && !s_q.mc_ill |-> dec_data_addr == dec_buf_addr + `MMSH_BUF_DATA)
        else $error("data area not twelve words past base");

    AST_TTAG: assert property (
        s_q.st == ST_IDLE && cmd_stb |=> dec_time_tag == $past(tt_now))
        else $error("time tag not captured at command");

    AST_VONLY: assert property (
        s_q.st == ST_END && msg_done && s_q.flg[`MMSH_FLG_VONLY] && s_q.to_ring
        && !msg_valid |=> !commit_stb)
        else $error("invalid message committed to ring");

    AST_IRQ: assert property (
        s_q.st == ST_END && msg_done && !s_q.mc_ill && s_q.flg[`MMSH_FLG_EOMINT]
        && !s_q.flg[`MMSH_FLG_VINT] |=> irq_stb)
        else $error("end-of-message interrupt missing");

    AST_MCILL: assert property (
        s_q.st == ST_END && msg_done && s_q.mc_ill |=> !irq_stb)
        else $error("interrupt raised for illegal mode code");

    COV_SIM: cover property (dec_stb && sim_mode && dec_fetch_ndp);
    COV_STOP_START: cover property (!rec_on ##[1:200] rec_on);
    COV_IRQ: cover property (irq_stb);
    COV_MCILL: cover property (dec_stb && s_q.mc_ill);
endmodule : mmsh_top

//--- src/mmsh_ttc.sv
// Board-wide free-running time tag counter with pulsed clear.
// Assumes clr is a one-cycle strobe on clk.
`timescale 1ns/100ps
module mmsh_ttc
    import mmsh_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic        clr,
    output logic [31:0]      count
);
    mmsh_ttc_s s_q;   // Registered state
    mmsh_ttc_s s_d;   // Next state

    ////////////////////////////////////////////////////////////////////////
    // Count every cycle, clear to zero on request
    always_comb begin
        s_d = s_q;
        s_d.cnt = clr ? 32'h0000_0000 : s_q.cnt + 32'h0000_0001;
    end

    // State register
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign count = s_q.cnt;

    AST_TT_CLEAR: assert property (@(posedge clk) disable iff (!rstn)
        clr |=> s_q.cnt == 32'h0000_0000)
        else $error("time tag not cleared");
endmodule : mmsh_ttc
